// File: core/usm_pkg.sv
package usm_pkg;
    // register byte addresses
    localparam logic [7:0] OFS_BAUD   = 8'h00;
    localparam logic [7:0] OFS_RCCTL  = 8'h04;
    localparam logic [7:0] OFS_DIVLO  = 8'h08;
    localparam logic [7:0] OFS_DIVHI  = 8'h0C;
    localparam logic [7:0] OFS_TXHOLD = 8'h10;
    localparam logic [7:0] OFS_TXCTL  = 8'h14;
    localparam logic [7:0] OFS_RXDATA = 8'h18;
    localparam logic [7:0] OFS_FLAGS  = 8'h1C;

    // baud_control fields
    localparam int BIT_POL  = 4;
    localparam int BIT_WIDE = 3;
    // receive_status_control fields
    localparam int BIT_PEN  = 7;
    localparam int BIT_RX9  = 6;
    localparam int BIT_SINGLE_RECEIVE_ENABLE = 5;
    localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int BIT_OVR  = 1;
    localparam int BIT_RECEIVE_NINTH_BIT = 0;
    // transmit_status_control fields
    localparam int BIT_MSTR = 7;
    localparam int BIT_TX9  = 6;
    localparam int BIT_TRANSMIT_ENABLE = 5;
    localparam int BIT_SYNC = 4;
    localparam int BIT_HIGH = 2;
    localparam int BIT_TEMP = 1;
    localparam int BIT_TRANSMIT_NINTH_BIT = 0;
    // flag register fields
    localparam int BIT_RXF  = 0;
    localparam int BIT_TXF  = 1;

    // reset values and writable masks
    localparam logic [7:0] RST_REG   = 8'h00;
    localparam logic [7:0] MSK_BAUD  = 8'h18;
    localparam logic [7:0] MSK_RCCTL = 8'hF0;
    localparam logic [7:0] MSK_TXCTL = 8'hF5;

    // character lengths
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;

    // shift engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10
    } usm_state_e;

    // two-way pin drive group
    typedef struct packed {
        logic clkOut;
        logic clkOe;
        logic dataOut;
        logic dataOe;
    } usm_pins_s;

    // bits per character
    function automatic logic [3:0] charBits(input logic nine);
        return nine ? BITS_9 : BITS_8;
    endfunction : charBits
endpackage : usm_pkg

// File: core/usm_rx_fifo.sv
`timescale 1ns/1ps
module usm_rx_fifo (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       flush,
    input  wire logic       push,
    input  wire logic [8:0] pushData,
    input  wire logic       pop,
    output logic      [8:0] head,
    output logic            empty,
    output logic            full
);
    logic [1:0] cnt_q;
    logic [8:0] slot0_q;
    logic [8:0] slot1_q;
    logic       doPush;
    logic       doPop;

    // guarded strobes
    assign doPush = push && (cnt_q != 2'd2);
    assign doPop  = pop && (cnt_q != 2'd0);
    assign head   = slot0_q;
    assign empty  = (cnt_q == 2'd0);
    assign full   = (cnt_q == 2'd2);

    // oldest entry always sits in slot0
    always_ff @(posedge clk_sys) begin
        if (rst || flush) begin
            cnt_q   <= 2'd0;
            slot0_q <= 9'h000;
            slot1_q <= 9'h000;
        end else if (doPush && doPop) begin
            if (cnt_q == 2'd1) begin
                slot0_q <= pushData;
            end else begin
                slot0_q <= slot1_q;
                slot1_q <= pushData;
            end
        end else if (doPop) begin
            slot0_q <= slot1_q;
            cnt_q   <= cnt_q - 2'd1;
        end else if (doPush) begin
            if (cnt_q == 2'd0) begin
                slot0_q <= pushData;
            end else begin
                slot1_q <= pushData;
            end
            cnt_q <= cnt_q + 2'd1;
        end
    end
endmodule : usm_rx_fifo

// File: core/usm_top.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module usm_top (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              clk_pin_in,
    input  wire logic              data_pin_in,
    output usm_pkg::usm_pins_s     pins
);
    logic [7:0]          baudCtl_q;
    logic [7:0]          rcCtl_q;
    logic [7:0]          divLo_q;
    logic [7:0]          divHi_q;
    logic [7:0]          txCtl_q;
    logic [31:0]         prdata_q;
    logic [7:0]          rdMux;
    logic                wrEn;
    logic                setupRd;
    logic                rdData;
    logic                mapped;
    logic                portOn;
    logic                master;
    logic                rxMode;
    logic                cont;
    logic                single;
    logic                pol;
    logic [2:0]          ckSync_q;
    logic [1:0]          dtSync_q;
    logic                extLead;
    logic                extTrail;
    logic [15:0]         baudCnt_q;
    logic [15:0]         divider;
    logic                tick;
    usm_pkg::usm_state_e st_q;
    logic [3:0]          bitCnt_q;
    logic                engRx_q;
    logic [8:0]          txSh_q;
    logic                txNine_q;
    logic [8:0]          rxSh_q;
    logic [8:0]          rxChar;
    logic                leadEv;
    logic                trailEv;
    logic                lastBit;
    logic                abort;
    logic                rxDone;
    logic                txLoad;
    logic                txTake;
    logic [8:0]          txHold_q;
    logic                txFull_q;
    logic                dataOut_q;
    logic                ovr_q;
    logic                ovrSingle_q;
    logic                fifoEmpty;
    logic                fifoFull;
    logic [8:0]          fifoHead;
    logic                push;
    logic                pop;

    // apb decode, zero wait states
    assign wrEn    = psel && penable && pwrite;
    assign setupRd = psel && !penable && !pwrite;
    assign rdData  = psel && penable && !pwrite && (paddr == usm_pkg::OFS_RXDATA);
    assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= usm_pkg::OFS_FLAGS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_q;

    // mode decode
    assign portOn = rcCtl_q[usm_pkg::BIT_PEN] && txCtl_q[usm_pkg::BIT_SYNC];
    assign master = txCtl_q[usm_pkg::BIT_MSTR];
    assign single = rcCtl_q[usm_pkg::BIT_SINGLE_RECEIVE_ENABLE];
    assign cont   = rcCtl_q[usm_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE];
    assign rxMode = single || cont;
    assign pol    = baudCtl_q[usm_pkg::BIT_POL];

    // register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            baudCtl_q <= usm_pkg::RST_REG;
            divLo_q   <= usm_pkg::RST_REG;
            divHi_q   <= usm_pkg::RST_REG;
            txCtl_q   <= usm_pkg::RST_REG;
        end else if (wrEn) begin
            unique case (paddr)
                usm_pkg::OFS_BAUD:  baudCtl_q <= pwdata[7:0] & usm_pkg::MSK_BAUD;
                usm_pkg::OFS_DIVLO: divLo_q   <= pwdata[7:0];
                usm_pkg::OFS_DIVHI: divHi_q   <= pwdata[7:0];
                usm_pkg::OFS_TXCTL: txCtl_q   <= pwdata[7:0] & usm_pkg::MSK_TXCTL;
                default: ;
            endcase
        end
    end

    // receive control, hardware clears single receive
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rcCtl_q <= usm_pkg::RST_REG;
        end else if (wrEn && paddr == usm_pkg::OFS_RCCTL) begin
            rcCtl_q <= pwdata[7:0] & usm_pkg::MSK_RCCTL;
        end else if (rxDone) begin
            rcCtl_q[usm_pkg::BIT_SINGLE_RECEIVE_ENABLE] <= 1'b0;
        end
    end

    // read mux
    always_comb begin
        rdMux = 8'h00;
        unique case (paddr)
            usm_pkg::OFS_BAUD:   rdMux = baudCtl_q;
            usm_pkg::OFS_RCCTL:  rdMux = {rcCtl_q[7:4], 2'b00, ovr_q, fifoHead[8]};
            usm_pkg::OFS_DIVLO:  rdMux = divLo_q;
            usm_pkg::OFS_DIVHI:  rdMux = divHi_q;
            usm_pkg::OFS_TXCTL:  rdMux = txCtl_q | {6'h00, (st_q == usm_pkg::ST_IDLE), 1'b0};
            usm_pkg::OFS_RXDATA: rdMux = fifoHead[7:0];
            usm_pkg::OFS_FLAGS:  rdMux = {6'h00, !txFull_q, !fifoEmpty};
            default:             rdMux = 8'h00;
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setupRd) begin
            prdata_q <= {24'h00_0000, rdMux};
        end
    end

    // pin synchronisers, first stage read only by second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ckSync_q <= 3'b000;
            dtSync_q <= 2'b00;
        end else begin
            ckSync_q <= {ckSync_q[1:0], clk_pin_in};
            dtSync_q <= {dtSync_q[0], data_pin_in};
        end
    end

    // external clock edges mapped by polarity
    assign extLead  = pol ? (!ckSync_q[1] && ckSync_q[2]) : (ckSync_q[1] && !ckSync_q[2]);
    assign extTrail = pol ? (ckSync_q[1] && !ckSync_q[2]) : (!ckSync_q[1] && ckSync_q[2]);

    // baud tick, half a shift clock per reload
    assign divider = baudCtl_q[usm_pkg::BIT_WIDE] ? {divHi_q, divLo_q} : {8'h00, divLo_q};
    assign tick    = master && (st_q != usm_pkg::ST_IDLE) && (baudCnt_q == 16'h0000);

    always_ff @(posedge clk_sys) begin
        if (rst || !master || st_q == usm_pkg::ST_IDLE || tick) begin
            baudCnt_q <= divider;
        end else begin
            baudCnt_q <= baudCnt_q - 16'h0001;
        end
    end

    // engine events
    assign leadEv  = (st_q == usm_pkg::ST_LOW) && (master ? tick : extLead);
    assign trailEv = (st_q == usm_pkg::ST_HIGH) && (master ? tick : extTrail);
    assign lastBit = (bitCnt_q + 4'h1) ==
                     usm_pkg::charBits(engRx_q ? rcCtl_q[usm_pkg::BIT_RX9] : txNine_q);
    assign abort   = (st_q != usm_pkg::ST_IDLE) && (engRx_q != rxMode);
    assign rxDone  = trailEv && engRx_q && lastBit && !abort;
    assign txLoad  = portOn && txFull_q && txCtl_q[usm_pkg::BIT_TRANSMIT_ENABLE] && !rxMode;
    assign txTake  = txLoad && !abort && ((st_q == usm_pkg::ST_IDLE) ||
                     (trailEv && lastBit && !engRx_q));

    // received character with current bit merged in
    always_comb begin
        rxChar = rxSh_q;
        rxChar[bitCnt_q] = dtSync_q[1];
        if (!rcCtl_q[usm_pkg::BIT_RX9]) begin
            rxChar[8] = 1'b0;
        end
    end

    // shift engine, shared by both directions
    always_ff @(posedge clk_sys) begin
        if (rst || !portOn) begin
            st_q     <= usm_pkg::ST_IDLE;
            bitCnt_q <= 4'h0;
            engRx_q  <= 1'b0;
            txSh_q   <= 9'h000;
            txNine_q <= 1'b0;
            rxSh_q   <= 9'h000;
        end else if (abort) begin
            st_q     <= usm_pkg::ST_IDLE;
            bitCnt_q <= 4'h0;
        end else begin
            unique case (st_q)
                usm_pkg::ST_IDLE: begin
                    bitCnt_q <= 4'h0;
                    rxSh_q   <= 9'h000;
                    if (rxMode && !ovr_q) begin
                        st_q    <= usm_pkg::ST_LOW;
                        engRx_q <= 1'b1;
                    end else if (txTake) begin
                        st_q     <= usm_pkg::ST_LOW;
                        engRx_q  <= 1'b0;
                        txSh_q   <= txHold_q;
                        txNine_q <= txCtl_q[usm_pkg::BIT_TX9];
                    end
                end
                usm_pkg::ST_LOW: begin
                    if (leadEv) begin
                        st_q <= usm_pkg::ST_HIGH;
                    end
                end
                usm_pkg::ST_HIGH: begin
                    if (trailEv) begin
                        if (engRx_q) begin
                            rxSh_q <= rxChar;
                        end
                        if (!lastBit) begin
                            bitCnt_q <= bitCnt_q + 4'h1;
                            st_q     <= usm_pkg::ST_LOW;
                        end else begin
                            bitCnt_q <= 4'h0;
                            rxSh_q   <= 9'h000;
                            if (engRx_q) begin
                                // continuous keeps clocking unless overrun
                                st_q <= (cont && !fifoFull) ? usm_pkg::ST_LOW
                                                            : usm_pkg::ST_IDLE;
                            end else if (txTake) begin
                                st_q     <= usm_pkg::ST_LOW;
                                txSh_q   <= txHold_q;
                                txNine_q <= txCtl_q[usm_pkg::BIT_TX9];
                            end else begin
                                st_q <= usm_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                default: st_q <= usm_pkg::ST_IDLE;
            endcase
        end
    end

    // transmit holding register, write wins over take
    always_ff @(posedge clk_sys) begin
        if (rst || !rcCtl_q[usm_pkg::BIT_PEN]) begin
            txHold_q <= 9'h000;
            txFull_q <= 1'b0;
        end else if (wrEn && paddr == usm_pkg::OFS_TXHOLD) begin
            txHold_q <= {txCtl_q[usm_pkg::BIT_TRANSMIT_NINTH_BIT], pwdata[7:0]};
            txFull_q <= 1'b1;
        end else if (txTake) begin
            txFull_q <= 1'b0;
        end
    end

    // data bit changes only on leading edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dataOut_q <= 1'b0;
        end else if (leadEv && !engRx_q) begin
            dataOut_q <= txSh_q[bitCnt_q];
        end
    end

    // pin drivers
    assign pins.dataOut = dataOut_q;
    assign pins.dataOe  = portOn && !rxMode &&
                          !(engRx_q && st_q != usm_pkg::ST_IDLE);
    assign pins.clkOe   = portOn && master;
    assign pins.clkOut  = pol ^ (master && st_q == usm_pkg::ST_HIGH);

    // overrun, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (rst || !rcCtl_q[usm_pkg::BIT_PEN]) begin
            ovr_q       <= 1'b0;
            ovrSingle_q <= 1'b0;
        end else if (rxDone && fifoFull) begin
            ovr_q       <= 1'b1;
            ovrSingle_q <= single && !cont;
        end else if (ovr_q && ((ovrSingle_q && rdData) || (!ovrSingle_q && !cont))) begin
            ovr_q <= 1'b0;
        end
    end

    assign push = rxDone && !fifoFull && !ovr_q;
    assign pop  = rdData && !fifoEmpty;

    // two-entry receive fifo
    usm_rx_fifo u_fifo (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .flush    (!rcCtl_q[usm_pkg::BIT_PEN]),
        .push     (push),
        .pushData (rxChar),
        .pop      (pop),
        .head     (fifoHead),
        .empty    (fifoEmpty),
        .full     (fifoFull)
    );

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    chk_idle_clock: assert property (st_q == usm_pkg::ST_IDLE |-> pins.clkOut == pol)
        else $error("clock pin not at idle level");
    chk_rx_no_drive: assert property (portOn && rxMode |-> !pins.dataOe)
        else $error("data driven in receive mode");
    chk_half_duplex: assert property (engRx_q && st_q != usm_pkg::ST_IDLE |-> !pins.dataOe)
        else $error("driving data while receiving");
    chk_single_done: assert property (rxDone && single && !wrEn |=> !single)
        else $error("single receive not cleared");
    chk_both_cont: assert property (rxDone && single && cont && !fifoFull && !wrEn
        |=> st_q == usm_pkg::ST_LOW && cont)
        else $error("continuous receive did not carry on");
    chk_tx_stable: assert property (st_q == usm_pkg::ST_HIGH && !engRx_q && !abort
        |=> $stable(pins.dataOut))
        else $error("transmit bit changed off leading edge");
    chk_bit_bound: assert property (st_q != usm_pkg::ST_IDLE |-> bitCnt_q < usm_pkg::BITS_9)
        else $error("too many bits in character");
    chk_tx_start: assert property (txTake && st_q == usm_pkg::ST_IDLE |=>
        st_q == usm_pkg::ST_LOW ##0 !txFull_q || $past(wrEn))
        else $error("holding register not moved to shifter");
    chk_abort_stop: assert property (abort |=> st_q == usm_pkg::ST_IDLE)
        else $error("partial character not discarded");
    chk_rx_flag: assert property (push |=> !fifoEmpty)
        else $error("receive flag not set");
    chk_overrun_keep: assert property (rxDone && fifoFull && !pop |=> ovr_q && $stable(fifoHead))
        else $error("overrun not flagged or fifo overwritten");
    chk_ovr_block: assert property (ovr_q && st_q == usm_pkg::ST_IDLE |=> !engRx_q || st_q == usm_pkg::ST_IDLE)
        else $error("reception resumed under overrun");

    cov_master_tx: cover property (master && txTake ##[1:300] txFull_q == 1'b0 && st_q == usm_pkg::ST_IDLE);
    cov_single_rx: cover property (rxDone && single && !cont);
    cov_overrun: cover property (rxDone && fifoFull);
    cov_slave_rx: cover property (!master && rxDone);
endmodule : usm_top

// File: tb/tb_usart_synchronous_mode.sv
`timescale 1ns/1ps
module tb_usart_synchronous_mode;
    logic               clk_sys = 1'b0;
    logic               rst     = 1'b1;
    logic               psel    = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite  = 1'b0;
    logic [7:0]         paddr   = 8'h00;
    logic [31:0]        pwdata  = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    usm_pkg::usm_pins_s pins;
    logic               pol     = 1'b0;
    logic               nine    = 1'b0;
    logic               drive   = 1'b0;
    logic               master  = 1'b0;
    logic [8:0]         seed    = 9'h000;
    logic               pClk;
    logic               pData;
    wire                clkWire  = pins.clkOe ? pins.clkOut : pClk;
    wire                dataWire = pins.dataOe ? pins.dataOut : pData;
    int                 miscompares  = 0;
    int                 total_checks = 0;
    int                 cycles = 0;
    int                 e0;
    int                 h0;

    usm_top uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_pin_in(clkWire), .data_pin_in(dataWire), .pins(pins));
    usm_partner farEnd (.clk_sys(clk_sys), .pol(pol), .nine(nine), .drive(drive),
        .master(master), .seed(seed), .clkWire(clkWire), .dataWire(dataWire),
        .clkOut(pClk), .dataOut(pData));

    // 10 MHz system clock
    always #50 clk_sys = ~clk_sys;

    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one APB transfer, held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        xfer(1'b0, a, 8'h00, r, e);
        check(r, exp);
    endtask : rd

    // poll a register until all bits of m are set, bounded
    task automatic wait_bit(input logic [7:0] a, input logic [7:0] m);
        logic [31:0] r;
        logic        e;
        int          n;
        n = 0;
        r = 32'h0;
        while ((r[7:0] & m) !== m && n < 300) begin
            xfer(1'b0, a, 8'h00, r, e);
            n++;
        end
        check({24'h000000, r[7:0] & m}, {24'h000000, m});
    endtask : wait_bit

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rd(usm_pkg::OFS_FLAGS, 32'h2);
        rd(usm_pkg::OFS_RCCTL, 32'h0);
        xfer(1'b0, 8'h20, 8'h00, r, e);
        check({31'h0, e}, 32'h1);
        check(r, 32'h0);
        wr(usm_pkg::OFS_BAUD, 8'hFF);
        rd(usm_pkg::OFS_BAUD, 32'h18);
        $display("test regs done");
    endtask : t_regs

    task automatic t_tx(input logic p);
        pol <= p;
        drive <= 1'b0;
        master <= 1'b0;
        wr(usm_pkg::OFS_BAUD, {3'h0, p, 4'h0});
        wr(usm_pkg::OFS_DIVLO, 8'h03);
        wr(usm_pkg::OFS_TXCTL, 8'hB0);
        wr(usm_pkg::OFS_RCCTL, 8'h80);
        repeat (4) @(posedge clk_sys);
        e0 = farEnd.edges;
        h0 = farEnd.holdErrs;
        wr(usm_pkg::OFS_TXHOLD, 8'hA5);
        wait_bit(usm_pkg::OFS_FLAGS, 8'h02);
        wr(usm_pkg::OFS_TXHOLD, 8'h3C);
        wait_bit(usm_pkg::OFS_TXCTL, 8'h02);
        check(farEnd.edges - e0, 16);
        check({16'h0, farEnd.rxWord}, 32'h3CA5);
        check(farEnd.holdErrs - h0, 0);
        check({29'h0, pins.clkOut, pins.clkOe, pins.dataOe}, {29'h0, p, 2'b11});
        $display("test transmit done");
    endtask : t_tx

    task automatic t_rx9;
        seed <= 9'h1A5;
        nine <= 1'b1;
        wr(usm_pkg::OFS_TXCTL, 8'h90);
        drive <= 1'b1;
        e0 = farEnd.edges;
        wr(usm_pkg::OFS_RCCTL, 8'hE0);
        check({31'h0, pins.dataOe}, 32'h0);
        wait_bit(usm_pkg::OFS_FLAGS, 8'h01);
        check({31'h0, pins.dataOe}, 32'h1);
        rd(usm_pkg::OFS_RCCTL, 32'hC1);
        rd(usm_pkg::OFS_RXDATA, 32'hA5);
        rd(usm_pkg::OFS_FLAGS, 32'h2);
        check(farEnd.edges - e0, 9);
        $display("test receive done");
    endtask : t_rx9

    task automatic t_ovr;
        nine <= 1'b0;
        seed <= 9'h05A;
        wr(usm_pkg::OFS_RCCTL, 8'h90);
        repeat (20) @(posedge clk_sys);
        drive <= 1'b0;
        wr(usm_pkg::OFS_RCCTL, 8'h80);
        repeat (2) @(posedge clk_sys);
        e0 = farEnd.edges;
        repeat (40) @(posedge clk_sys);
        check(farEnd.edges - e0, 0);
        rd(usm_pkg::OFS_FLAGS, 32'h2);
        drive <= 1'b1;
        wr(usm_pkg::OFS_RCCTL, 8'hB0);
        wait_bit(usm_pkg::OFS_RCCTL, 8'h02);
        repeat (100) @(posedge clk_sys);
        check(farEnd.edges - e0, 24);
        rd(usm_pkg::OFS_RXDATA, 32'h5A);
        rd(usm_pkg::OFS_FLAGS, 32'h3);
        rd(usm_pkg::OFS_RXDATA, 32'h5A);
        rd(usm_pkg::OFS_RCCTL, 32'h92);
        wr(usm_pkg::OFS_RCCTL, 8'h80);
        rd(usm_pkg::OFS_RCCTL, 32'h80);
        // three single receives fill the fifo and overrun it
        repeat (3) begin
            wr(usm_pkg::OFS_RCCTL, 8'hA0);
            wait_bit(usm_pkg::OFS_TXCTL, 8'h02);
        end
        rd(usm_pkg::OFS_RCCTL, 32'h82);
        rd(usm_pkg::OFS_RXDATA, 32'h5A);
        rd(usm_pkg::OFS_RCCTL, 32'h80);
        rd(usm_pkg::OFS_RXDATA, 32'h5A);
        $display("test overrun done");
    endtask : t_ovr

    task automatic t_slave;
        pol <= 1'b0;
        master <= 1'b1;
        drive <= 1'b0;
        seed <= 9'h0C3;
        wr(usm_pkg::OFS_BAUD, 8'h00);
        wr(usm_pkg::OFS_TXCTL, 8'h10);
        drive <= 1'b1;
        wr(usm_pkg::OFS_RCCTL, 8'h90);
        check({31'h0, pins.clkOe}, 32'h0);
        farEnd.clock_out(8);
        wait_bit(usm_pkg::OFS_FLAGS, 8'h01);
        rd(usm_pkg::OFS_RXDATA, 32'hC3);
        drive <= 1'b0;
        wr(usm_pkg::OFS_RCCTL, 8'h80);
        wr(usm_pkg::OFS_TXCTL, 8'h71);
        wr(usm_pkg::OFS_TXHOLD, 8'h96);
        farEnd.clock_out(9);
        repeat (8) @(posedge clk_sys);
        check({23'h0, farEnd.rxWord[15:7]}, 32'h196);
        $display("test slave done");
    endtask : t_slave

    // reset, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_tx(1'b0);
        t_tx(1'b1);
        t_rx9();
        t_ovr();
        t_slave();
        complete_run();
    end
endmodule : tb_usart_synchronous_mode

// File: tb/usm_partner.sv
`timescale 1ns/1ps
// far end of the link: shifts a seed word out, collects what it sees on the wire
module usm_partner (
    input  wire logic       clk_sys,
    input  wire logic       pol,
    input  wire logic       nine,
    input  wire logic       drive,
    input  wire logic       master,
    input  wire logic [8:0] seed,
    input  wire logic       clkWire,
    input  wire logic       dataWire,
    output logic            clkOut,
    output logic            dataOut
);
    logic        clkPrev  = 1'b0;
    logic        dataPrev = 1'b0;
    logic        genClk   = 1'b0;
    logic        spin     = 1'b0;
    logic [8:0]  txWord   = 9'h000;
    logic [15:0] rxWord   = 16'h0000;
    int          edges    = 0;
    int          holdErrs = 0;
    wire         lead     = clkWire != clkPrev && clkWire != pol;
    wire         trail    = clkWire != clkPrev && clkWire == pol;

    initial dataOut = 1'b0;
    // a released line shows a changing pattern, never the last value
    assign clkOut = master ? genClk : spin;

    // sample on trailing edges, shift on leading edges, watch data hold
    always @(posedge clk_sys) begin
        clkPrev <= clkWire;
        dataPrev <= dataWire;
        spin <= ~spin;
        if (trail) begin
            rxWord <= {dataWire, rxWord[15:1]};
            edges <= edges + 1;
        end
        if (!drive && dataWire != dataPrev && clkPrev != pol) begin
            holdErrs <= holdErrs + 1;
        end
        if (!drive) begin
            txWord <= seed;
            dataOut <= ~dataOut;
        end else if (lead) begin
            dataOut <= txWord[0];
            txWord <= nine ? {txWord[0], txWord[8:1]} : {1'b0, txWord[0], txWord[7:1]};
        end
    end

    // exactly n clock cycles at 800 ns, idle level between frames
    task automatic clock_out(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_sys);
            genClk <= ~pol;
            repeat (4) @(posedge clk_sys);
            genClk <= pol;
        end
    endtask : clock_out
endmodule : usm_partner
